// file: shared/stm_pkg.sv
// package: register map, field layouts and types of the split-mode timer
//
// Functional notes
// - mode 3 splits first timer into bytes
// - low byte uses first run/select/gate/flag
// - low byte counts clock or input falls
// - high byte is timer only, never events
// - high byte runs on second run bit
// - high byte overflow sets second flag
// - second timer runs, no events, no flag
// - second timer overflow still feeds baud
// - second timer stops when its mode is 3
// - flags: hardware sets, software/vector clears
// - count needs run and open gate, except in mode 3: high byte needs only second run bit, second timer neither
package stm_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;

    // register byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFS_MODE   = 12'h080;
    localparam logic [ADDR_W-1:0] OFS_CLKSEL = 12'h084;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h088;
    localparam logic [ADDR_W-1:0] OFS_T0LO   = 12'h08C;
    localparam logic [ADDR_W-1:0] OFS_T0HI   = 12'h090;
    localparam logic [ADDR_W-1:0] OFS_T1LO   = 12'h094;
    localparam logic [ADDR_W-1:0] OFS_T1HI   = 12'h098;
    localparam logic [ADDR_W-1:0] OFS_ISTAT  = 12'h09C;
    localparam logic [ADDR_W-1:0] OFS_IMASK  = 12'h0A0;

    // reset values
    localparam logic [BYTE_W-1:0] CTRL_RST  = 8'h00;
    localparam logic [BYTE_W-1:0] MODE_RST  = 8'h00;
    localparam logic [3:0]        CLK_RST   = 4'h0;
    localparam logic [BYTE_W-1:0] COUNT_RST = 8'h00;
    localparam logic [1:0]        IRQ_RST   = 2'h0;

    // interrupt status / mask bit positions
    localparam int unsigned IRQ_T0 = 0;
    localparam int unsigned IRQ_T1 = 1;

    // all-ones low byte of the mode-2 reload test
    localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hFF;

    // per-timer operating modes
    typedef enum logic [1:0] {
        STM_MODE13,
        STM_MODE16,
        STM_MODE8R,
        STM_SPLIT
    } stm_mode_t;

    // one half of the mode register
    typedef struct packed {
        logic      gate;   // gate by external input
        logic      ct;     // 1 = count input falls
        stm_mode_t mode;
    } stm_tcfg_t;

    // timer_mode_register: second timer in the upper nibble
    typedef struct packed {
        stm_tcfg_t t1;
        stm_tcfg_t t0;
    } stm_tmode_t;

    // timer_run_and_flag_control layout
    typedef struct packed {
        logic       tf1;
        logic       tr1;
        logic       tf0;
        logic       tr0;
        logic [3:0] ext;   // external interrupt bits, storage only
    } stm_ctrl_t;

    // clock and gate-polarity selection
    typedef struct packed {
        logic pol1;    // active level of second gate input
        logic pol0;    // active level of first gate input
        logic t1_sys;  // 1 = system clock, 0 = prescaled
        logic t0_sys;
    } stm_clk_t;

endpackage

// file: core/stm_timer.sv
// split-mode timer pair with control register and apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
module stm_timer #(
    parameter int unsigned PRESCALE_DIV = 12  // prescaled tick period
) (
    input  wire logic        pclk,         // system clock
    input  wire logic        presetn,      // async reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb access phase
    input  wire logic        pwrite,       // apb direction
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error, unmapped
    input  wire logic        t0_count_in,  // first external count input
    input  wire logic        t1_count_in,  // second external count input
    input  wire logic        first_external_gate_input,  // gate 0
    input  wire logic        second_external_gate_input, // gate 1
    input  wire logic        t0_vector_ack, // cpu vectors to first isr
    input  wire logic        t1_vector_ack, // cpu vectors to second isr
    output logic             t0_int_req,   // first overflow flag level
    output logic             t1_int_req,   // second overflow flag level
    output logic             baud_tick,    // second timer overflow pulse
    output logic             irq           // masked sticky interrupt
);

    localparam int unsigned PW = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_DIV - 1);

    stm_pkg::stm_ctrl_t  ctrl_r, ctrl_nxt;
    stm_pkg::stm_tmode_t mode_r;
    stm_pkg::stm_clk_t   clk_r;
    logic [7:0]  t0lo_r, t0hi_r, t1lo_r, t1hi_r;
    logic [7:0]  t0lo_nxt, t0hi_nxt, t1lo_nxt, t1hi_nxt;
    logic [1:0]  istat_r, imask_r;
    logic [PW-1:0] pre_r;
    logic        pre_tick;
    logic        t0in_q_r, t1in_q_r;
    logic        fall0, fall1;
    logic        ovf_t0, ovf_t1flag, ovf_t1baud;
    logic        baud_tick_r;
    logic        wr_en, rd_en, mapped;
    logic [31:0] rdata_r;

    // full-timer step for modes 0..2; split mode is handled outside
    function automatic logic [16:0] stm_step(
        input stm_pkg::stm_mode_t m,
        input logic [7:0]         lo,
        input logic [7:0]         hi
    );
        logic [13:0] s13;
        logic [16:0] r;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        r   = {1'b0, hi, lo};
        case (m)
            stm_pkg::STM_MODE13: begin
                r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
            end
            stm_pkg::STM_MODE16: begin
                r = {1'b0, hi, lo} + 17'h0_0001;
            end
            stm_pkg::STM_MODE8R: begin
                if (lo == stm_pkg::BYTE_ONES) begin
                    r = {1'b1, hi, hi};
                end else begin
                    r = {1'b0, hi, lo + 8'h01};
                end
            end
            default: begin
                r = {1'b0, hi, lo};
            end
        endcase
        return r;
    endfunction

    // free-running 8-bit split counter, wraps with no reload
    function automatic logic [8:0] stm_inc8(input logic [7:0] v);
        return {1'b0, v} + 9'h001;
    endfunction

    // address decode for the write path and pslverr; the read path decodes on its own
    function automatic logic stm_hit(input logic [11:0] a);
        return (a == stm_pkg::OFS_MODE)  || (a == stm_pkg::OFS_CLKSEL) ||
               (a == stm_pkg::OFS_CTRL)  || (a == stm_pkg::OFS_T0LO)   ||
               (a == stm_pkg::OFS_T0HI)  || (a == stm_pkg::OFS_T1LO)   ||
               (a == stm_pkg::OFS_T1HI)  || (a == stm_pkg::OFS_ISTAT)  ||
               (a == stm_pkg::OFS_IMASK);
    endfunction

    // zero-wait slave; writes land in the access phase
    assign mapped  = stm_hit(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en   = psel && penable && pwrite && mapped;
    assign rd_en   = psel && !penable && !pwrite;
    assign prdata  = rdata_r;

    // prescaler: one-cycle enable every PRESCALE_DIV clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= '0;
        end else if (pre_r == PRE_LAST) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PW'(1);
        end
    end
    assign pre_tick = (pre_r == PRE_LAST);

    // falling-edge detect of external count inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0in_q_r <= 1'b0;
            t1in_q_r <= 1'b0;
        end else begin
            t0in_q_r <= t0_count_in;
            t1in_q_r <= t1_count_in;
        end
    end
    assign fall0 = t0in_q_r && !t0_count_in;
    assign fall1 = t1in_q_r && !t1_count_in;

    // counting: split mode reroutes run, clock and flags
    always_comb begin
        logic        split0, run0, run1, tmr0, tmr1, tick0, tick1;
        logic [16:0] s0, s1;
        logic [8:0]  lo8, hi8;
        split0 = (mode_r.t0.mode == stm_pkg::STM_SPLIT);
        tmr0   = clk_r.t0_sys ? 1'b1 : pre_tick;
        tmr1   = clk_r.t1_sys ? 1'b1 : pre_tick;
        run0   = ctrl_r.tr0 && (!mode_r.t0.gate ||
                 (first_external_gate_input == clk_r.pol0));
        run1   = ctrl_r.tr1 && (!mode_r.t1.gate ||
                 (second_external_gate_input == clk_r.pol1));
        tick0  = mode_r.t0.ct ? fall0 : tmr0;
        tick1  = tmr1;
        t0lo_nxt   = t0lo_r;
        t0hi_nxt   = t0hi_r;
        t1lo_nxt   = t1lo_r;
        t1hi_nxt   = t1hi_r;
        ovf_t0     = 1'b0;
        ovf_t1flag = 1'b0;
        ovf_t1baud = 1'b0;
        s0  = stm_step(mode_r.t0.mode, t0lo_r, t0hi_r);
        s1  = stm_step(mode_r.t1.mode, t1lo_r, t1hi_r);
        lo8 = stm_inc8(t0lo_r);
        hi8 = stm_inc8(t0hi_r);
        if (split0) begin
            // low byte keeps the first timer's controls
            if (run0 && tick0) begin
                t0lo_nxt = lo8[7:0];
                ovf_t0   = lo8[8];
            end
            // high byte: timer only, second run bit
            if (ctrl_r.tr1 && tmr0) begin
                t0hi_nxt   = hi8[7:0];
                ovf_t1flag = hi8[8];
            end
        end else if (run0 && tick0) begin
            t0lo_nxt = s0[7:0];
            t0hi_nxt = s0[15:8];
            ovf_t0   = s0[16];
        end
        // second timer: in split mode runs on its mode, no events
        if (split0) begin
            tick1 = tmr1;
            run1  = (mode_r.t1.mode != stm_pkg::STM_SPLIT);
        end else begin
            tick1 = mode_r.t1.ct ? fall1 : tmr1;
            run1  = run1 && (mode_r.t1.mode != stm_pkg::STM_SPLIT);
        end
        if (run1 && tick1) begin
            t1lo_nxt   = s1[7:0];
            t1hi_nxt   = s1[15:8];
            ovf_t1baud = s1[16];
            if (!split0 && s1[16]) begin
                ovf_t1flag = 1'b1;
            end
        end
        // software writes take precedence over a same-cycle count
        if (wr_en && paddr == stm_pkg::OFS_T0LO) begin
            t0lo_nxt = pwdata[7:0];
        end
        if (wr_en && paddr == stm_pkg::OFS_T0HI) begin
            t0hi_nxt = pwdata[7:0];
        end
        if (wr_en && paddr == stm_pkg::OFS_T1LO) begin
            t1lo_nxt = pwdata[7:0];
        end
        if (wr_en && paddr == stm_pkg::OFS_T1HI) begin
            t1hi_nxt = pwdata[7:0];
        end
    end

    // count registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0lo_r <= stm_pkg::COUNT_RST;
            t0hi_r <= stm_pkg::COUNT_RST;
            t1lo_r <= stm_pkg::COUNT_RST;
            t1hi_r <= stm_pkg::COUNT_RST;
        end else begin
            t0lo_r <= t0lo_nxt;
            t0hi_r <= t0hi_nxt;
            t1lo_r <= t1lo_nxt;
            t1hi_r <= t1hi_nxt;
        end
    end

    // control register; a hardware set beats any clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en && paddr == stm_pkg::OFS_CTRL) begin
            ctrl_nxt = stm_pkg::stm_ctrl_t'(pwdata[7:0]);
        end
        if (t0_vector_ack) begin
            ctrl_nxt.tf0 = 1'b0;
        end
        if (t1_vector_ack) begin
            ctrl_nxt.tf1 = 1'b0;
        end
        if (ovf_t0) begin
            ctrl_nxt.tf0 = 1'b1;
        end
        if (ovf_t1flag) begin
            ctrl_nxt.tf1 = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= stm_pkg::stm_ctrl_t'(stm_pkg::CTRL_RST);
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // mode and clock-select registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= stm_pkg::stm_tmode_t'(stm_pkg::MODE_RST);
            clk_r  <= stm_pkg::stm_clk_t'(stm_pkg::CLK_RST);
        end else begin
            if (wr_en && paddr == stm_pkg::OFS_MODE) begin
                mode_r <= stm_pkg::stm_tmode_t'(pwdata[7:0]);
            end
            if (wr_en && paddr == stm_pkg::OFS_CLKSEL) begin
                clk_r <= stm_pkg::stm_clk_t'(pwdata[3:0]);
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r <= stm_pkg::IRQ_RST;
            imask_r <= stm_pkg::IRQ_RST;
        end else begin
            if (wr_en && paddr == stm_pkg::OFS_ISTAT) begin
                istat_r <= (istat_r & ~pwdata[1:0]) |
                           {ovf_t1flag, ovf_t0};
            end else begin
                istat_r <= istat_r | {ovf_t1flag, ovf_t0};
            end
            if (wr_en && paddr == stm_pkg::OFS_IMASK) begin
                imask_r <= pwdata[1:0];
            end
        end
    end
    assign irq        = |(istat_r & imask_r);
    assign t0_int_req = ctrl_r.tf0;
    assign t1_int_req = ctrl_r.tf1;

    // baud pulse to serial ports, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_tick_r <= 1'b0;
        end else begin
            baud_tick_r <= ovf_t1baud;
        end
    end
    assign baud_tick = baud_tick_r;

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
        end else if (rd_en) begin
            if (paddr == stm_pkg::OFS_MODE) begin
                rdata_r <= {24'h00_0000, mode_r};
            end else if (paddr == stm_pkg::OFS_CLKSEL) begin
                rdata_r <= {28'h000_0000, clk_r};
            end else if (paddr == stm_pkg::OFS_CTRL) begin
                rdata_r <= {24'h00_0000, ctrl_r};
            end else if (paddr == stm_pkg::OFS_T0LO) begin
                rdata_r <= {24'h00_0000, t0lo_r};
            end else if (paddr == stm_pkg::OFS_T0HI) begin
                rdata_r <= {24'h00_0000, t0hi_r};
            end else if (paddr == stm_pkg::OFS_T1LO) begin
                rdata_r <= {24'h00_0000, t1lo_r};
            end else if (paddr == stm_pkg::OFS_T1HI) begin
                rdata_r <= {24'h00_0000, t1hi_r};
            end else if (paddr == stm_pkg::OFS_ISTAT) begin
                rdata_r <= {30'h0000_0000, istat_r};
            end else if (paddr == stm_pkg::OFS_IMASK) begin
                rdata_r <= {30'h0000_0000, imask_r};
            end else begin
                rdata_r <= '0;
            end
        end
    end

endmodule

// file: dv/stm_timer_asserts.sv
// port checker for the split-mode timer, bound to its top module
`timescale 1ns/10ps
module stm_timer_asserts #(
    parameter int unsigned PRESCALE_DIV = 12  // prescaled tick period
) (
    input wire logic        pclk,                        // clock
    input wire logic        presetn,                     // reset, low
    input wire logic        psel,                        // apb select
    input wire logic        penable,                     // apb access
    input wire logic        pwrite,                      // apb direction
    input wire logic [11:0] paddr,                       // apb address
    input wire logic [31:0] pwdata,                      // apb wdata
    input wire logic [31:0] prdata,                      // apb rdata
    input wire logic        pready,                      // apb ready
    input wire logic        pslverr,                     // apb error
    input wire logic        t0_count_in,                 // count in 0
    input wire logic        t1_count_in,                 // count in 1
    input wire logic        first_external_gate_input,   // gate 0
    input wire logic        second_external_gate_input,  // gate 1
    input wire logic        t0_vector_ack,               // ack 0
    input wire logic        t1_vector_ack,               // ack 1
    input wire logic        t0_int_req,                  // flag 0
    input wire logic        t1_int_req,                  // flag 1
    input wire logic        baud_tick,                   // baud pulse
    input wire logic        irq                          // interrupt
);
    // access decode; map is word aligned from mode to mask
    wire logic acc     = psel & penable;
    wire logic mapped  = (paddr[1:0] == 2'h0) &&
                         (paddr >= stm_pkg::OFS_MODE) &&
                         (paddr <= stm_pkg::OFS_IMASK);
    wire logic ctrl_wr = acc & pwrite & (paddr == stm_pkg::OFS_CTRL);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (acc && mapped |-> pready && !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (
        acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_rd: assert property (
        acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_set0_write: assert property (ctrl_wr && pwdata[5] |=> t0_int_req)
        else $error("first flag not set by write");
    a_set1_write: assert property (ctrl_wr && pwdata[7] |=> t1_int_req)
        else $error("second flag not set by write");
    a_flag0_clear: assert property (
        $fell(t0_int_req) |-> $past(t0_vector_ack) || $past(ctrl_wr))
        else $error("first flag cleared without cause");
    a_flag1_clear: assert property (
        $fell(t1_int_req) |-> $past(t1_vector_ack) || $past(ctrl_wr))
        else $error("second flag cleared without cause");
    a_reset_quiet: assert property (
        $rose(presetn) |->
        !t0_int_req && !t1_int_req && !irq && !baud_tick)
        else $error("outputs active after reset");

    // main scenarios reached
    c_high_ovf: cover property ($rose(t1_int_req));
    c_baud:     cover property (baud_tick);
    c_irq:      cover property ($rose(irq));
    c_unmapped: cover property (acc && !mapped);
endmodule

bind stm_timer stm_timer_asserts #(.PRESCALE_DIV(PRESCALE_DIV)) u_chk (.*);

// file: dv/stm_timer_tb_top.sv
// self-checking bench for the split-mode timer
`timescale 1ns/10ps
module stm_timer_tb_top;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } stm_row_t;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rd2;
    logic        err;
    logic        pready, pslverr, t0_count_in, t1_count_in;
    logic        first_timer_gate_bit, gate1, ack0, ack1;
    logic        t0_int_req, t1_int_req, baud_tick, irq;
    int          n_mismatch;
    int          num_checks;
    stm_row_t    rows [9];

    stm_timer #(.PRESCALE_DIV(2)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .t0_count_in(t0_count_in),
        .t1_count_in(t1_count_in), .first_external_gate_input(first_timer_gate_bit),
        .second_external_gate_input(gate1), .t0_vector_ack(ack0),
        .t1_vector_ack(ack1), .t0_int_req(t0_int_req),
        .t1_int_req(t1_int_req), .baud_tick(baud_tick), .irq(irq)
    );

    // free-running 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        #1;
        if (n >= 50) begin
            chk("pready", 0, 1);
            give_verdict();
        end
    endtask

    // bounded wait for flag 0, flag 1 or baud pulse
    task automatic wait_hi(input int k);
        int n;
        n = 0;
        while (n < 600 && !(k == 0 ? t0_int_req === 1'b1 :
               k == 1 ? t1_int_req === 1'b1 : baud_tick === 1'b1)) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 600) begin
            chk("wait", k, 32'hffff_ffff);
            give_verdict();
        end
    endtask

    // event falls on both inputs; high held two clocks, low at least two
    task automatic falls(input int n);
        repeat (n) begin
            @(posedge pclk); t0_count_in <= 1'b1; t1_count_in <= 1'b1;
            repeat (2) @(posedge pclk);
            t0_count_in <= 1'b0; t1_count_in <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask

    initial begin
        rows = '{
            '{stm_pkg::OFS_MODE,   32'h0000_0033, 32'h0000_0033},
            '{stm_pkg::OFS_CLKSEL, 32'h0000_0003, 32'h0000_0003},
            '{stm_pkg::OFS_T0LO,   32'h0000_00fe, 32'h0000_00fe},
            '{stm_pkg::OFS_T0HI,   32'h0000_00fd, 32'h0000_00fd},
            '{stm_pkg::OFS_T1LO,   32'h0000_00fc, 32'h0000_00fc},
            '{stm_pkg::OFS_T1HI,   32'h0000_00f0, 32'h0000_00f0},
            '{stm_pkg::OFS_IMASK,  32'h0000_0003, 32'h0000_0003},
            '{stm_pkg::OFS_CTRL,   32'h0000_000f, 32'h0000_000f},
            '{12'h0a4,             32'h0000_0055, 32'h0000_0000}};
        n_mismatch = 0; num_checks = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; t0_count_in = 1'b0;
        t1_count_in = 1'b0; first_timer_gate_bit = 1'b1; gate1 = 1'b1; ack0 = 1'b0;
        ack1 = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, stm_pkg::OFS_CTRL, 0); chk("ctrl rst", rd, 0);
        chk("mapped err", err, 0);
        // table rows: write then read back
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d);
            apb(0, rows[i].a, 0);
            chk("row", rd, rows[i].e);
        end
        // last row is the unmapped address
        chk("unmapped err", err, 1);
        // low byte on first run bit; high byte held without second run
        apb(1, stm_pkg::OFS_CTRL, 32'h10);
        wait_hi(0);
        apb(0, stm_pkg::OFS_T0HI, 0); chk("hi held", rd, 32'hfd);
        apb(1, stm_pkg::OFS_CTRL, 32'h40);
        chk("tf0 sw clr", t0_int_req, 0);
        apb(0, stm_pkg::OFS_T0LO, 0); rd2 = rd;
        apb(0, stm_pkg::OFS_T0LO, 0); chk("lo stop", rd, rd2);
        wait_hi(1);
        // vector ack clears second flag
        @(posedge pclk); ack1 <= 1'b1;
        @(posedge pclk); ack1 <= 1'b0;
        #1 chk("tf1 ack", t1_int_req, 0);
        // software set of first flag, then vector ack clears it
        apb(1, stm_pkg::OFS_CTRL, 32'h20);
        chk("tf0 sw set", t0_int_req, 1);
        @(posedge pclk); ack0 <= 1'b1;
        @(posedge pclk); ack0 <= 1'b0;
        #1 chk("tf0 ack", t0_int_req, 0);
        // gated event counting on the low byte
        apb(1, stm_pkg::OFS_CTRL, 0);
        apb(1, stm_pkg::OFS_MODE, 32'h3f);
        apb(1, stm_pkg::OFS_T0LO, 0);
        apb(1, stm_pkg::OFS_CTRL, 32'h10);
        falls(3);
        apb(0, stm_pkg::OFS_T0LO, 0); chk("gated", rd, 0);
        @(posedge pclk);
        first_timer_gate_bit <= 1'b0;
        falls(3);
        apb(0, stm_pkg::OFS_T0LO, 0); chk("events", rd, 3);
        // second timer in mode 2 runs on mode alone, no flag
        apb(1, stm_pkg::OFS_CTRL, 0);
        apb(1, stm_pkg::OFS_MODE, 32'he3);
        wait_hi(2);
        @(posedge pclk);
        #1 chk("baud 1cyc", baud_tick, 0);
        repeat (40) @(posedge pclk);
        #1 chk("no tf1", t1_int_req, 0);
        apb(1, stm_pkg::OFS_MODE, 32'h33);
        apb(0, stm_pkg::OFS_T1LO, 0); rd2 = rd;
        apb(0, stm_pkg::OFS_T1LO, 0); chk("t1 stop", rd, rd2);
        // second timer in modes 1 and 0 also feeds baud, sets no flag
        apb(1, stm_pkg::OFS_T1HI, 32'hff);
        apb(1, stm_pkg::OFS_T1LO, 32'hfe);
        apb(1, stm_pkg::OFS_MODE, 32'h13);
        wait_hi(2);
        apb(1, stm_pkg::OFS_MODE, 32'h33);
        apb(1, stm_pkg::OFS_T1HI, 32'hff);
        apb(1, stm_pkg::OFS_T1LO, 32'h1e);
        apb(1, stm_pkg::OFS_MODE, 32'h03);
        wait_hi(2);
        chk("no tf1 m0", t1_int_req, 0);
        apb(1, stm_pkg::OFS_MODE, 32'h33);
        // sticky status, mask and clear
        chk("irq on", irq, 1);
        apb(1, stm_pkg::OFS_IMASK, 0); chk("irq mask", irq, 0);
        apb(1, stm_pkg::OFS_ISTAT, 32'h3);
        apb(0, stm_pkg::OFS_ISTAT, 0); chk("istat w1c", rd, 0);
        apb(1, stm_pkg::OFS_IMASK, 32'h3); chk("irq off", irq, 0);
        // reset in mid-run
        @(posedge pclk); presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, stm_pkg::OFS_CTRL, 0); chk("ctrl rst2", rd, 0);
        apb(0, stm_pkg::OFS_T0LO, 0); chk("lo rst2", rd, 0);
        give_verdict();
    end
endmodule
